// ### design/fpst_pkg.sv
package fpst_pkg;
  localparam logic [7:0] FPST_IDX_MOD  = 8'hD9;
  localparam logic [7:0] FPST_IDX_DISP = 8'hDA;
  localparam logic [7:0] FPST_IDX_STBY = 8'hDB;
  localparam logic [7:0] FPST_RST_VAL  = 8'h00;
  localparam int FPST_WGT_HI = 7;
  localparam int FPST_WGT_LO = 5;
  localparam int FPST_SIZE_HI = 4;
  localparam int FPST_SIZE_LO = 3;
  localparam int FPST_ALIGN_HI = 2;
  localparam int FPST_ALIGN_LO = 1;
  localparam int FPST_GRAY32_BIT = 0;
  localparam int FPST_MODE_HI = 7;
  localparam int FPST_MODE_LO = 6;
  localparam int FPST_IVL_HI = 5;
  localparam int FPST_IVL_LO = 0;
  localparam int FPST_CLK_HZ = 50000000;
  localparam int FPST_MINUTE_S = 60;
  // 3e9 cycles overflows a signed int, so the count is held in 64 bits
  localparam longint FPST_MINUTE_CYC = longint'(FPST_CLK_HZ) * FPST_MINUTE_S;
  localparam logic [6:0] FPST_W11 = 7'h0B;
  localparam logic [6:0] FPST_W30 = 7'h1E;
  localparam logic [6:0] FPST_W59 = 7'h3B;
  typedef enum logic [1:0] {
    FPST_MODE_OFF  = 2'b00,
    FPST_MODE_SSC  = 2'b01,
    FPST_MODE_VMEM = 2'b10,
    FPST_MODE_RSV  = 2'b11
  } fpst_mode_t;
  typedef enum logic [1:0] {
    FPST_ALIGN_TOP = 2'b00,
    FPST_ALIGN_BOT = 2'b01,
    FPST_ALIGN_CTR = 2'b10
  } fpst_align_t;
  typedef enum logic [1:0] {
    FPST_SIZE_480 = 2'b00,
    FPST_SIZE_400 = 2'b01,
    FPST_SIZE_RSV = 2'b10
  } fpst_size_t;
endpackage

// ### design/fpst_tmr_if.sv
`timescale 1ns/1ns
`default_nettype none
interface fpst_tmr_if;
  logic       enable;
  logic       restart;
  logic [5:0] minutes;
  logic       expired;
  modport ctrl (output enable, output restart, output minutes, input expired);
  modport tmr  (input enable, input restart, input minutes, output expired);
endinterface
`default_nettype wire

// ### design/fpst_standby_timer.sv
`timescale 1ns/1ns
`default_nettype none
module fpst_standby_timer #(
  parameter longint MINUTE_CYC = fpst_pkg::FPST_MINUTE_CYC
) (
  input  wire logic  clk_sys,
  input  wire logic  rst,
  fpst_tmr_if.tmr    tif
);
  import fpst_pkg::*;
  logic [31:0] tick_r;
  logic [5:0]  min_r;
  logic        exp_r;
  logic        min_done;
  assign min_done = (tick_r == 32'(MINUTE_CYC - 1));
  always_ff @(posedge clk_sys) begin
    if (rst || !tif.enable || tif.restart || min_done) begin
      tick_r <= '0;
    end else begin
      tick_r <= tick_r + 32'h1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst || !tif.enable || tif.restart) begin
      min_r <= '0;
    end else if (min_done && min_r != 6'h3F) begin
      min_r <= min_r + 6'h1;
    end
  end
  // raise on interval reached; zero interval expires at once
  always_ff @(posedge clk_sys) begin
    if (rst || !tif.enable || tif.restart) begin
      exp_r <= 1'b0;
    end else if (min_r >= tif.minutes) begin
      exp_r <= 1'b1;
    end
  end
  assign tif.expired = exp_r;
  property p_exp_clear;
    @(posedge clk_sys) disable iff (rst)
    tif.restart |=> !tif.expired;
  endproperty
  a_exp_clear: assert property (p_exp_clear)
    else $error("expiry survived a restart");

  property p_off_quiet;
    @(posedge clk_sys) disable iff (rst)
    !tif.enable |=> !tif.expired;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("disabled timer expired");
endmodule
`default_nettype wire

// ### design/fpst_flat_panel_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module fpst_flat_panel_ctrl #(
  parameter longint MINUTE_CYC = fpst_pkg::FPST_MINUTE_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [7:0]  io_index,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        io_wr,
  output logic      [7:0]  io_rdata,
  output logic             io_hit,
  input  wire logic        line_clk_pulse,
  input  wire logic [7:0]  gray_in,
  input  wire logic [5:0]  pix_red,
  input  wire logic [5:0]  pix_green,
  input  wire logic [5:0]  pix_blue,
  input  wire logic        screen_save_clock_in,
  input  wire logic        vmem_cpu_req,
  output logic             panel_polarity_wave_out,
  output logic      [5:0]  gray_out,
  output logic      [5:0]  gray_shade,
  output logic      [9:0]  panel_lines,
  output fpst_pkg::fpst_align_t panel_align,
  output logic             standby_req
);
  import fpst_pkg::*;
  logic [7:0] panel_modulation_period_r;
  logic [7:0] panel_display_control_r;
  logic [7:0] standby_timer_control_r;
  logic [7:0] mod_cnt_r;
  logic       wave_r;
  logic       ssc_q_r;
  logic [5:0] gray_r;
  logic [6:0] wr_w, wg_w, wb_w;
  logic [14:0] sum_w;
  fpst_mode_t mode_w;
  fpst_tmr_if tif ();

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      panel_modulation_period_r <= FPST_RST_VAL;
      panel_display_control_r   <= FPST_RST_VAL;
      standby_timer_control_r   <= FPST_RST_VAL;
    end else if (io_wr) begin
      case (io_index)
        FPST_IDX_MOD:  panel_modulation_period_r <= io_wdata;
        FPST_IDX_DISP: panel_display_control_r   <= io_wdata;
        FPST_IDX_STBY: standby_timer_control_r   <= io_wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    io_hit = 1'b1;
    case (io_index)
      FPST_IDX_MOD:  io_rdata = panel_modulation_period_r;
      FPST_IDX_DISP: io_rdata = panel_display_control_r;
      FPST_IDX_STBY: io_rdata = standby_timer_control_r;
      default: begin
        io_rdata = 8'h00;
        io_hit   = 1'b0;
      end
    endcase
  end

  // half period counted in line clocks; a zero value holds the wave still
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mod_cnt_r <= 8'h00;
      wave_r    <= 1'b0;
    end else if (line_clk_pulse && panel_modulation_period_r != 8'h00) begin
      if (mod_cnt_r + 8'h01 >= panel_modulation_period_r) begin
        mod_cnt_r <= 8'h00;
        wave_r    <= ~wave_r;
      end else begin
        mod_cnt_r <= mod_cnt_r + 8'h01;
      end
    end
  end
  assign panel_polarity_wave_out = wave_r;

  // weight permutation select; reserved codes fall back to the default
  always_comb begin
    case (panel_display_control_r[FPST_WGT_HI:FPST_WGT_LO])
      3'b001: begin
        wr_w = FPST_W30;
        wg_w = FPST_W11;
        wb_w = FPST_W59;
      end
      3'b010: begin
        wr_w = FPST_W11;
        wg_w = FPST_W59;
        wb_w = FPST_W30;
      end
      3'b011: begin
        wr_w = FPST_W30;
        wg_w = FPST_W59;
        wb_w = FPST_W11;
      end
      3'b100: begin
        wr_w = FPST_W59;
        wg_w = FPST_W11;
        wb_w = FPST_W30;
      end
      3'b101: begin
        wr_w = FPST_W59;
        wg_w = FPST_W30;
        wb_w = FPST_W11;
      end
      default: begin
        wr_w = FPST_W11;
        wg_w = FPST_W30;
        wb_w = FPST_W59;
      end
    endcase
    sum_w = 15'(pix_red * wr_w) + 15'(pix_green * wg_w) + 15'(pix_blue * wb_w);
  end

  // gray limit drops the lowest shade bit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gray_r <= 6'h00;
    end else if (panel_display_control_r[FPST_GRAY32_BIT]) begin
      gray_r <= {gray_in[7:3], 1'b0};
    end else begin
      gray_r <= gray_in[7:2];
    end
  end
  assign gray_out = gray_r;
  // percent weights sum to 100; /100 is an integer divide, fraction dropped, clamped
  assign gray_shade = (sum_w / 15'd100 > 15'd63) ? 6'h3F : 6'(sum_w / 15'd100);

  // size select; reserved codes keep 480 lines
  assign panel_lines = (panel_display_control_r[FPST_SIZE_HI:FPST_SIZE_LO] == FPST_SIZE_400)
                       ? 10'd400 : 10'd480;
  assign panel_align = panel_display_control_r[FPST_ALIGN_HI] ? FPST_ALIGN_CTR
                     : fpst_align_t'(panel_display_control_r[FPST_ALIGN_HI:FPST_ALIGN_LO]);

  assign mode_w = fpst_mode_t'(standby_timer_control_r[FPST_MODE_HI:FPST_MODE_LO]);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ssc_q_r <= 1'b0;
    end else begin
      ssc_q_r <= screen_save_clock_in;
    end
  end

  assign tif.enable = (mode_w == FPST_MODE_SSC) || (mode_w == FPST_MODE_VMEM);
  // screen-save edge restarts; memory request restarts
  assign tif.restart = ((mode_w == FPST_MODE_SSC) && (ssc_q_r != screen_save_clock_in))
                    || ((mode_w == FPST_MODE_VMEM) && vmem_cpu_req);
  assign tif.minutes = standby_timer_control_r[FPST_IVL_HI:FPST_IVL_LO];

  fpst_standby_timer #(.MINUTE_CYC(MINUTE_CYC)) u_tmr (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tif     (tif)
  );
  assign standby_req = tif.expired;

  property p_wr_mod;
    @(posedge clk_sys) disable iff (rst)
    io_wr && io_index == FPST_IDX_MOD |=> panel_modulation_period_r == $past(io_wdata);
  endproperty
  a_wr_mod: assert property (p_wr_mod)
    else $error("modulation write lost");

  property p_wr_stby;
    @(posedge clk_sys) disable iff (rst)
    io_wr && io_index == FPST_IDX_STBY |=> standby_timer_control_r == $past(io_wdata);
  endproperty
  a_wr_stby: assert property (p_wr_stby)
    else $error("standby write lost");

  property p_wave_hold;
    @(posedge clk_sys) disable iff (rst)
    !line_clk_pulse |=> $stable(panel_polarity_wave_out);
  endproperty
  a_wave_hold: assert property (p_wave_hold)
    else $error("wave moved");

  property p_wave_one;
    @(posedge clk_sys) disable iff (rst)
    line_clk_pulse && panel_modulation_period_r == 8'h01 && $past(!rst)
      |=> panel_polarity_wave_out != $past(panel_polarity_wave_out);
  endproperty
  a_wave_one: assert property (p_wave_one)
    else $error("unit half period");

  property p_gray32;
    @(posedge clk_sys) disable iff (rst)
    panel_display_control_r[FPST_GRAY32_BIT] && $stable(panel_display_control_r)
      |=> !gray_out[0];
  endproperty
  a_gray32: assert property (p_gray32)
    else $error("32 shade limit broken");

  property p_centre;
    @(posedge clk_sys) disable iff (rst)
    panel_display_control_r[FPST_ALIGN_HI] |-> panel_align == FPST_ALIGN_CTR;
  endproperty
  a_centre: assert property (p_centre)
    else $error("centre alignment");

  property p_size;
    @(posedge clk_sys) disable iff (rst)
    panel_display_control_r[FPST_SIZE_HI:FPST_SIZE_LO] == 2'b01 |-> panel_lines == 10'd400;
  endproperty
  a_size: assert property (p_size)
    else $error("size select");

  property p_vmem;
    @(posedge clk_sys) disable iff (rst)
    mode_w == FPST_MODE_VMEM && vmem_cpu_req |=> !standby_req;
  endproperty
  a_vmem: assert property (p_vmem)
    else $error("memory request did not restart");

  property p_weight;
    @(posedge clk_sys) disable iff (rst)
    panel_display_control_r[FPST_WGT_HI:FPST_WGT_LO] == 3'b100 |-> wr_w == FPST_W59;
  endproperty
  a_weight: assert property (p_weight)
    else $error("weight select");
endmodule
`default_nettype wire

// ### test/fpst_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module fpst_host_model (
  input  wire logic       clk_sys,
  input  wire logic       req,
  input  wire logic [7:0] req_idx,
  input  wire logic [7:0] req_dat,
  output logic      [7:0] io_index,
  output logic      [7:0] io_wdata,
  output logic            io_wr
);
  initial begin
    io_index = 8'h00;
    io_wdata = 8'h00;
    io_wr    = 1'b0;
  end
  // indexed port access
  // released data is inverted so a stale byte never passes for a write
  always @(posedge clk_sys) begin
    io_index <= req_idx;
    io_wr    <= req;
    io_wdata <= req ? req_dat : ~io_wdata;
  end
endmodule
`default_nettype wire

// ### test/tb_flat_panel_ctrl_standby_timer.sv
`timescale 1ns/1ns
`default_nettype none
module tb_flat_panel_ctrl_standby_timer;
  import fpst_pkg::*;
  logic        clk_sys = 0, rst = 1, req = 0, lclk = 0, ssc = 0, vreq = 0;
  logic [7:0]  ridx = 0, rdat = 0, gin = 0, idx, wd, rdata, d;
  logic [5:0]  pr = 0, pg = 0, pb = 0, gout, gsh;
  logic        wr, hit, wave, sreq;
  logic [9:0]  lines;
  fpst_align_t algn;
  int          failures = 0, compares = 0, cyc = 0, seed = 95, n, k, e;
  int          mdl[3], rw[6] = '{11, 30, 11, 30, 59, 59};
  int          gw[6] = '{30, 11, 59, 59, 11, 30}, bw[6] = '{59, 59, 30, 11, 30, 11};
  logic [7:0]  dt[5] = '{8'h43, 8'h83, 8'h41, 8'h03, 8'hC3};
  fpst_host_model host_u (.clk_sys(clk_sys), .req(req), .req_idx(ridx), .req_dat(rdat),
    .io_index(idx), .io_wdata(wd), .io_wr(wr));
  fpst_flat_panel_ctrl #(.MINUTE_CYC(10)) dut_u (.clk_sys(clk_sys), .rst(rst),
    .io_index(idx), .io_wdata(wd), .io_wr(wr), .io_rdata(rdata), .io_hit(hit),
    .line_clk_pulse(lclk), .gray_in(gin), .pix_red(pr), .pix_green(pg), .pix_blue(pb),
    .screen_save_clock_in(ssc), .vmem_cpu_req(vreq), .panel_polarity_wave_out(wave),
    .gray_out(gout), .gray_shade(gsh), .panel_lines(lines), .panel_align(algn),
    .standby_req(sreq));
  initial forever #10 clk_sys = ~clk_sys;
  task close_out;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end
  task chk(input string s, input logic [9:0] x, input logic [9:0] g);
    compares++;
    if (g !== x) begin
      failures++;
      $display("unexpected %s exp %0h got %0h", s, x, g);
    end
  endtask
  task wrt(input logic [7:0] i, input logic [7:0] v);
    @(posedge clk_sys);
    req <= 1;
    ridx <= i;
    rdat <= v;
    @(posedge clk_sys);
    req <= 0;
    if (i >= 8'hD9 && i <= 8'hDB) mdl[i - 8'hD9] = v;
  endtask
  task rdchk(input logic [7:0] i);
    @(posedge clk_sys);
    ridx <= i;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("rdata", (i >= 8'hD9 && i <= 8'hDB) ? mdl[i - 8'hD9] : 0, rdata);
    chk("hit", i >= 8'hD9 && i <= 8'hDB, hit);
  endtask
  initial begin
    mdl = '{0, 0, 0};
    repeat (12) @(posedge clk_sys);
    rst <= 0;
    for (n = 0; n < 12; n++) begin
      k = 8'hD8 + {$random(seed)} % 5;
      wrt(k[7:0], $random(seed));
      rdchk(k[7:0]);
    end
    // second reset in mid-run brings every register back to zero
    @(posedge clk_sys);
    rst <= 1;
    @(posedge clk_sys);
    rst <= 0;
    mdl = '{0, 0, 0};
    for (k = 8'hD8; k <= 8'hDC; k++) rdchk(k[7:0]);
    chk("wave rst", 0, wave);
    // seven does not divide the line count
    wrt(8'hD9, 8'h07);
    for (n = 1; n <= 36; n++) begin
      @(posedge clk_sys);
      lclk <= 1;
      @(posedge clk_sys);
      lclk <= 0;
      @(posedge clk_sys);
      #1 chk("wave", (n / 7) % 2, wave);
      if (n == 30) wrt(8'hD9, 8'h07);
    end
    wrt(8'hD9, 8'h00);
    repeat (8) @(posedge clk_sys) lclk <= ~lclk;
    #1 chk("wave frozen", 1, wave);
    // unit half period flips the wave on every line clock
    wrt(8'hD9, 8'h01);
    repeat (2) @(posedge clk_sys) lclk <= ~lclk;
    #1 chk("wave unit", 0, wave);
    repeat (2) @(posedge clk_sys) lclk <= ~lclk;
    #1 chk("wave unit", 1, wave);
    for (n = 0; n < 32; n++) begin
      @(posedge clk_sys);
      pr <= $random(seed);
      pg <= $random(seed);
      pb <= $random(seed);
      gin <= $random(seed);
      d = {n[2:0], n[4:3], 3'($random(seed))};
      wrt(8'hDA, d);
      repeat (2) @(posedge clk_sys);
      #1 k = (d[7:5] > 5) ? 0 : d[7:5];
      e = (pr * rw[k] + pg * gw[k] + pb * bw[k]) / 100;
      chk("gray_shade", e, gsh);
      chk("panel_lines", (d[4:3] == 2'b01) ? 400 : 480, lines);
      chk("panel_align", d[2] ? 2 : d[1], algn);
      chk("gray_out", {gin[7:3], gin[2] & ~d[0]}, gout);
    end
    for (n = 0; n < 5; n++) begin
      wrt(8'hDB, 8'h00);
      wrt(8'hDB, dt[n]);
      e = (dt[n][7:6] == 2'b01 || dt[n][7:6] == 2'b10);
      repeat (20) @(posedge clk_sys);
      #1 chk("standby early", e && dt[n][5:0] == 1, sreq);
      repeat (20) @(posedge clk_sys);
      #1 chk("standby", e, sreq);
      @(posedge clk_sys);
      if (dt[n][7:6] == 2'b01) ssc <= ~ssc;
      else vreq <= 1;
      @(posedge clk_sys);
      vreq <= 0;
      @(posedge clk_sys);
      #1 chk("standby restart", 0, sreq);
    end
    close_out();
  end
endmodule
`default_nettype wire
